// ### asu_pkg.sv
/*
  Shared constants and carrier types for the asynchronous serial unit.
  Assumes a 32-bit classic Wishbone slave port with byte addresses.
*/
package asu_pkg;

  // Register byte offsets
  localparam logic [7:0] ASU_OFS_MODE = 8'h00;
  localparam logic [7:0] ASU_OFS_CTRL = 8'h04;
  localparam logic [7:0] ASU_OFS_BRG  = 8'h08;
  localparam logic [7:0] ASU_OFS_TXB  = 8'h0c;
  localparam logic [7:0] ASU_OFS_RXB  = 8'h10;
  localparam logic [7:0] ASU_OFS_STAT = 8'h14;

  // Character length codes and bit counts
  localparam logic [1:0] ASU_LEN7  = 2'h0;
  localparam logic [1:0] ASU_LEN8  = 2'h1;
  localparam logic [3:0] ASU_BITS7 = 4'h7;
  localparam logic [3:0] ASU_BITS8 = 4'h8;
  localparam logic [3:0] ASU_BITS9 = 4'h9;

  // Prescaler selections for the internal clock
  localparam logic [1:0] ASU_PRE_F1  = 2'h0;
  localparam logic [1:0] ASU_PRE_F8  = 2'h1;
  localparam logic [1:0] ASU_PRE_F32 = 2'h2;
  localparam logic [4:0] ASU_PRE8_LAST  = 5'h07;
  localparam logic [4:0] ASU_PRE32_LAST = 5'h1f;

  // Oversampling: sixteen ticks per bit, start checked at tick eight
  localparam logic [3:0] ASU_OS_LAST = 4'hf;
  localparam logic [3:0] ASU_OS_MID  = 4'h7;

  // Status bit positions
  localparam int ASU_ST_RXFULL = 0;
  localparam int ASU_ST_TXBE   = 1;
  localparam int ASU_ST_TXDONE = 2;
  localparam int ASU_ST_OVR    = 3;
  localparam int ASU_ST_FRM    = 4;
  localparam int ASU_ST_PAR    = 5;
  localparam int ASU_ST_SUM    = 6;

  // Frame format and line options
  typedef struct packed {
    logic       open_drain;
    logic       pol_rev;
    logic       data_inv;
    logic       sleep;
    logic       two_stop;
    logic       par_even;
    logic       par_en;
    logic [1:0] pre;
    logic       ext_clk;
    logic       rsv;
    logic [1:0] len;
  } asu_mode_t;

  // Transfer control and handshake selection
  typedef struct packed {
    logic hs_func_rts;
    logic hs_dis;
    logic tx_irq_done;
    logic clk_dir_out;
    logic rx_en;
    logic rsv;
    logic tx_en;
  } asu_ctrl_t;

  // Values after reset
  localparam logic [12:0] ASU_MODE_RST = 13'h0001;
  localparam logic [6:0]  ASU_CTRL_RST = 7'h00;
  localparam logic [7:0]  ASU_BRG_RST  = 8'h00;

endpackage

// ### asu_uart.sv
/*
  Asynchronous serial unit in UART mode: baud generator, transmitter,
  receiver, error flags, handshake pin and Wishbone register slave.
  Assumes pins arrive asynchronous to clk_i and that a port block
  outside owns the pins whenever they act as general ports.
*/
// Function
// - Frame is one start bit then seven, eight or nine character bits.
// - Optional odd or even parity bit follows the character bits.
// - Frame ends with one or two stop bits as configured.
// - Internal source: prescaled clock (1, 8, 32) divided by 16(n+1).
// - External source: transfer clock pin divided by 16(n+1).
// - Rate divisor is eight bits; divide factor is value plus one.
// - Send only if enabled, buffer loaded, and CTS low when selected.
// - Receive only if enabled and a start bit is detected.
// - Cause bit zero: transmit request when buffer moves to shifter.
// - Cause bit one: transmit request when whole frame is sent.
// - Receive request when a character lands in the receive buffer.
// - Overrun flagged when a character completes before previous is read.
// - On overrun the buffer is overwritten and no receive request raised.
// - Framing error when configured stop bits are not seen.
// - Parity error when ones count mismatches odd or even setting.
// - Error sum reads one while any error flag is set.
// - Sleep option lets one of several slaves be addressed.
// - Data inversion flips character bits only at buffer write and read.
// - Polarity reverse flips serial output and input at line level.
// - Serial output idles high, or floats in open-drain mode; with polarity reverse set it idles driven low in both modes.
// - Handshake pin: general port, CTS input or RTS output by two bits.
// - Clock pin is general port on internal clock, input on external.
// - In sleep mode only characters with MSB one are accepted.
`timescale 1ns/1ps
module asu_uart (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Serial pins
  input  wire logic        serial_in_pin_i,
  output logic             serial_out_pin_o,
  output logic             serial_out_pin_oe_o,
  input  wire logic        transfer_clock_pin_i,
  // Handshake pin
  input  wire logic        hs_pin_i,
  output logic             hs_pin_o,
  output logic             hs_pin_oe_o,
  // Interrupt request pulses
  output logic             tx_irq_req_o,
  output logic             rx_irq_req_o
);
  import asu_pkg::*;

  typedef enum logic [2:0] {ASU_TX_IDLE, ASU_TX_START, ASU_TX_DATA, ASU_TX_PAR,
                            ASU_TX_STOP} asu_tx_state_t;
  typedef enum logic [2:0] {ASU_RX_IDLE, ASU_RX_START, ASU_RX_DATA, ASU_RX_PAR,
                            ASU_RX_STOP} asu_rx_state_t;

  logic [12:0]   mode_reg;
  logic [6:0]    ctrl_reg;
  logic [7:0]    brg_reg;
  asu_mode_t     mode;
  asu_ctrl_t     ctrl;
  logic          bus_req;
  logic          wr_req;
  logic          rxb_rd;
  logic          stat_wr;
  logic [2:0]    rx_sync;
  logic [2:0]    ck_sync;
  logic [2:0]    hs_sync;
  logic          rx_filt;
  logic          ck_filt;
  logic          ck_filt_d;
  logic          hs_filt;
  logic          rx_line;
  logic [4:0]    pre_cnt;
  logic          pre_tick;
  logic          ext_sel;
  logic          src_tick;
  logic [7:0]    brg_cnt;
  logic          os_tick;
  logic [3:0]    nbits;
  logic [8:0]    len_mask;
  asu_tx_state_t tx_state;
  logic [3:0]    tx_os;
  logic [3:0]    tx_idx;
  logic [8:0]    txb_reg;
  logic          txbe_reg;
  logic [8:0]    tx_shift;
  logic          tx_par;
  logic          tx_line;
  logic          tx_bit_end;
  logic          cts_ok;
  logic          tx_go;
  asu_rx_state_t rx_state;
  logic [3:0]    rx_os;
  logic [3:0]    rx_idx;
  logic [8:0]    rx_shift;
  logic          rx_pbit;
  logic          rx_ferr;
  logic [8:0]    rxb_reg;
  logic          rx_full_reg;
  logic          ovr_reg;
  logic          frm_reg;
  logic          par_reg;
  logic          rx_samp;
  logic          rx_done;
  logic          rx_accept;
  logic          rx_perr;
  logic [31:0]   rd_word;

  assign mode = asu_mode_t'(mode_reg);
  assign ctrl = asu_ctrl_t'(ctrl_reg);

  // Bus decode; ack follows one cycle after the request
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_req  = bus_req & wb_we_i;
  assign rxb_rd  = bus_req & ~wb_we_i & (wb_adr_i == ASU_OFS_RXB);
  assign stat_wr = wr_req & (wb_adr_i == ASU_OFS_STAT) & wb_sel_i[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  // Configuration registers, byte lanes honoured
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_reg <= ASU_MODE_RST;
      ctrl_reg <= ASU_CTRL_RST;
      brg_reg  <= ASU_BRG_RST;
    end else if (wr_req) begin
      if (wb_adr_i == ASU_OFS_MODE) begin
        if (wb_sel_i[0]) mode_reg[7:0]  <= wb_dat_i[7:0];
        if (wb_sel_i[1]) mode_reg[12:8] <= wb_dat_i[12:8];
      end
      if (wb_adr_i == ASU_OFS_CTRL && wb_sel_i[0]) begin
        ctrl_reg <= wb_dat_i[6:0];
      end
      if (wb_adr_i == ASU_OFS_BRG && wb_sel_i[0]) begin
        brg_reg <= wb_dat_i[7:0];
      end
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    case (wb_adr_i)
      ASU_OFS_MODE: rd_word[12:0] = mode_reg;
      ASU_OFS_CTRL: rd_word[6:0]  = ctrl_reg;
      ASU_OFS_BRG:  rd_word[7:0]  = brg_reg;
      ASU_OFS_TXB:  rd_word[8:0]  = txb_reg;
      ASU_OFS_RXB:  rd_word[8:0]  = (rxb_reg ^ {9{mode.data_inv}}) & len_mask;
      ASU_OFS_STAT: begin
        rd_word[ASU_ST_RXFULL] = rx_full_reg;
        rd_word[ASU_ST_TXBE]   = txbe_reg;
        rd_word[ASU_ST_TXDONE] = txbe_reg & (tx_state == ASU_TX_IDLE);
        rd_word[ASU_ST_OVR]    = ovr_reg;
        rd_word[ASU_ST_FRM]    = frm_reg;
        rd_word[ASU_ST_PAR]    = par_reg;
        rd_word[ASU_ST_SUM]    = ovr_reg | frm_reg | par_reg;
      end
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Registered read data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_req && !wb_we_i) begin
      wb_dat_o <= rd_word;
    end
  end

  // Pin synchronisers; a change counts once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_sync   <= 3'h7;
      ck_sync   <= 3'h0;
      hs_sync   <= 3'h7;
      rx_filt   <= 1'b1;
      ck_filt   <= 1'b0;
      ck_filt_d <= 1'b0;
      hs_filt   <= 1'b1;
    end else begin
      rx_sync   <= {rx_sync[1:0], serial_in_pin_i};
      ck_sync   <= {ck_sync[1:0], transfer_clock_pin_i};
      hs_sync   <= {hs_sync[1:0], hs_pin_i};
      ck_filt_d <= ck_filt;
      if (rx_sync[1] == rx_sync[2]) rx_filt <= rx_sync[2];
      if (ck_sync[1] == ck_sync[2]) ck_filt <= ck_sync[2];
      if (hs_sync[1] == hs_sync[2]) hs_filt <= hs_sync[2];
    end
  end

  assign rx_line = rx_filt ^ mode.pol_rev;

  // Internal prescaler for f1, f8 and f32
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_cnt <= 5'h00;
    end else begin
      pre_cnt <= pre_cnt + 5'h01;
    end
  end

  assign pre_tick = (mode.pre == ASU_PRE_F1) |
                    ((mode.pre == ASU_PRE_F8) & (pre_cnt[2:0] == ASU_PRE8_LAST[2:0])) |
                    ((mode.pre == ASU_PRE_F32) & (pre_cnt == ASU_PRE32_LAST));
  assign ext_sel  = mode.ext_clk & ~ctrl.clk_dir_out;
  assign src_tick = ext_sel ? (ck_filt & ~ck_filt_d) : pre_tick;

  // Rate divisor: one oversample tick per n+1 source ticks
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      brg_cnt <= 8'h00;
    end else if (src_tick) begin
      brg_cnt <= (brg_cnt == 8'h00) ? brg_reg : brg_cnt - 8'h01;
    end
  end

  assign os_tick = src_tick & (brg_cnt == 8'h00);

  // Character length decode
  always_comb begin
    case (mode.len)
      ASU_LEN7: nbits = ASU_BITS7;
      ASU_LEN8: nbits = ASU_BITS8;
      default:  nbits = ASU_BITS9;
    endcase
    len_mask = ~(9'h1ff << nbits);
  end

  // Transmit buffer; inversion applied on write
  assign cts_ok = ctrl.hs_dis | ctrl.hs_func_rts | ~hs_filt;
  assign tx_go  = (tx_state == ASU_TX_IDLE) & ctrl.tx_en & ~txbe_reg & cts_ok;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      txb_reg  <= 9'h000;
      txbe_reg <= 1'b1;
    end else begin
      if (wr_req && wb_adr_i == ASU_OFS_TXB && wb_sel_i[0]) begin
        txb_reg[7:0] <= wb_dat_i[7:0] ^ {8{mode.data_inv}};
      end
      if (wr_req && wb_adr_i == ASU_OFS_TXB && wb_sel_i[1]) begin
        txb_reg[8] <= wb_dat_i[8] ^ mode.data_inv;
      end
      if (wr_req && wb_adr_i == ASU_OFS_TXB && wb_sel_i[0]) begin
        txbe_reg <= 1'b0;
      end else if (tx_go) begin
        txbe_reg <= 1'b1;
      end
    end
  end

  assign tx_bit_end = os_tick & (tx_os == ASU_OS_LAST);

  // Transmit frame sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_state     <= ASU_TX_IDLE;
      tx_os        <= 4'h0;
      tx_idx       <= 4'h0;
      tx_shift     <= 9'h000;
      tx_par       <= 1'b0;
      tx_line      <= 1'b1;
      tx_irq_req_o <= 1'b0;
    end else begin
      tx_irq_req_o <= 1'b0;
      if (os_tick) tx_os <= tx_os + 4'h1;
      case (tx_state)
        ASU_TX_IDLE: begin
          tx_line <= 1'b1;
          if (tx_go) begin
            tx_shift     <= txb_reg & len_mask;
            tx_par       <= ^(txb_reg & len_mask) ^ ~mode.par_even;
            tx_os        <= 4'h0;
            tx_line      <= 1'b0;
            tx_state     <= ASU_TX_START;
            tx_irq_req_o <= ~ctrl.tx_irq_done;
          end
        end
        ASU_TX_START: begin
          if (tx_bit_end) begin
            tx_line  <= tx_shift[0];
            tx_shift <= {1'b0, tx_shift[8:1]};
            tx_idx   <= 4'h1;
            tx_state <= ASU_TX_DATA;
          end
        end
        ASU_TX_DATA: begin
          if (tx_bit_end) begin
            if (tx_idx == nbits) begin
              tx_line  <= mode.par_en ? tx_par : 1'b1;
              tx_idx   <= 4'h0;
              tx_state <= mode.par_en ? ASU_TX_PAR : ASU_TX_STOP;
            end else begin
              tx_line  <= tx_shift[0];
              tx_shift <= {1'b0, tx_shift[8:1]};
              tx_idx   <= tx_idx + 4'h1;
            end
          end
        end
        ASU_TX_PAR: begin
          if (tx_bit_end) begin
            tx_line  <= 1'b1;
            tx_state <= ASU_TX_STOP;
          end
        end
        ASU_TX_STOP: begin
          if (tx_bit_end) begin
            if (mode.two_stop && tx_idx == 4'h0) begin
              tx_idx <= 4'h1;
            end else begin
              tx_state     <= ASU_TX_IDLE;
              tx_irq_req_o <= ctrl.tx_irq_done;
            end
          end
        end
        default: tx_state <= ASU_TX_IDLE;
      endcase
    end
  end

  // Line driver; open drain only pulls low
  assign serial_out_pin_o    = mode.open_drain ? 1'b0 : (tx_line ^ mode.pol_rev);
  assign serial_out_pin_oe_o = mode.open_drain ? ~(tx_line ^ mode.pol_rev) : 1'b1;

  // Handshake pin: RTS drive or released
  assign hs_pin_oe_o = ~ctrl.hs_dis & ctrl.hs_func_rts;
  assign hs_pin_o    = ~(ctrl.rx_en & ~rx_full_reg);

  assign rx_samp = os_tick & (rx_os == ASU_OS_LAST);

  // Receive frame sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_state <= ASU_RX_IDLE;
      rx_os    <= 4'h0;
      rx_idx   <= 4'h0;
      rx_shift <= 9'h000;
      rx_pbit  <= 1'b0;
      rx_ferr  <= 1'b0;
      rx_done  <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      if (os_tick) rx_os <= rx_os + 4'h1;
      case (rx_state)
        ASU_RX_IDLE: begin
          rx_os <= 4'h0;
          if (ctrl.rx_en && !rx_line) rx_state <= ASU_RX_START;
        end
        ASU_RX_START: begin
          if (os_tick && rx_os == ASU_OS_MID) begin
            rx_os    <= 4'h0;
            rx_idx   <= 4'h0;
            rx_shift <= 9'h000;
            rx_ferr  <= 1'b0;
            rx_state <= rx_line ? ASU_RX_IDLE : ASU_RX_DATA;
          end
        end
        ASU_RX_DATA: begin
          if (rx_samp) begin
            rx_shift[rx_idx] <= rx_line;
            if (rx_idx == nbits - 4'h1) begin
              rx_idx   <= 4'h0;
              rx_state <= mode.par_en ? ASU_RX_PAR : ASU_RX_STOP;
            end else begin
              rx_idx <= rx_idx + 4'h1;
            end
          end
        end
        ASU_RX_PAR: begin
          if (rx_samp) begin
            rx_pbit  <= rx_line;
            rx_state <= ASU_RX_STOP;
          end
        end
        ASU_RX_STOP: begin
          if (rx_samp) begin
            if (!rx_line) rx_ferr <= 1'b1;
            if (mode.two_stop && rx_idx == 4'h0) begin
              rx_idx <= 4'h1;
            end else begin
              rx_done  <= 1'b1;
              rx_state <= ASU_RX_IDLE;
            end
          end
        end
        default: rx_state <= ASU_RX_IDLE;
      endcase
    end
  end

  // Completion checks on the finished frame
  assign rx_perr   = mode.par_en & (^(rx_shift & len_mask) ^ rx_pbit ^ ~mode.par_even);
  assign rx_accept = rx_done & (~mode.sleep | rx_shift[nbits - 4'h1]);

  // Receive buffer and full flag; read clears, new data wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rxb_reg      <= 9'h000;
      rx_full_reg  <= 1'b0;
      rx_irq_req_o <= 1'b0;
    end else begin
      rx_irq_req_o <= rx_accept & (~rx_full_reg | rxb_rd);
      if (rx_accept) begin
        rxb_reg     <= rx_shift & len_mask;
        rx_full_reg <= 1'b1;
      end else if (rxb_rd) begin
        rx_full_reg <= 1'b0;
      end
    end
  end

  // Sticky error flags; write one to clear, a new error wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ovr_reg <= 1'b0;
      frm_reg <= 1'b0;
      par_reg <= 1'b0;
    end else begin
      if (rx_accept && rx_full_reg && !rxb_rd) begin
        ovr_reg <= 1'b1;
      end else if (stat_wr && wb_dat_i[ASU_ST_OVR]) begin
        ovr_reg <= 1'b0;
      end
      if (rx_accept && rx_ferr) begin
        frm_reg <= 1'b1;
      end else if (stat_wr && wb_dat_i[ASU_ST_FRM]) begin
        frm_reg <= 1'b0;
      end
      if (rx_accept && rx_perr) begin
        par_reg <= 1'b1;
      end else if (stat_wr && wb_dat_i[ASU_ST_PAR]) begin
        par_reg <= 1'b0;
      end
    end
  end

endmodule

// ### asu_chk.sv
/*
  Port checker for asu_uart, bound to every instance of it.
  Assumes the bus master writes whole words with every byte lane set.
*/
`timescale 1ns/1ps
module asu_chk
  import asu_pkg::*;
(
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Wishbone
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Pins and requests
  input wire logic        serial_in_pin_i,
  input wire logic        serial_out_pin_o,
  input wire logic        serial_out_pin_oe_o,
  input wire logic        transfer_clock_pin_i,
  input wire logic        hs_pin_i,
  input wire logic        hs_pin_o,
  input wire logic        hs_pin_oe_o,
  input wire logic        tx_irq_req_o,
  input wire logic        rx_irq_req_o
);
  asu_mode_t mode_reg;
  asu_ctrl_t ctrl_reg;
  logic      loaded_reg;
  logic      rd_stat_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Request taken at this edge
  wire logic take = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // Shadow copies of mode and control
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_reg   <= ASU_MODE_RST;
      ctrl_reg   <= ASU_CTRL_RST;
      loaded_reg <= 1'b0;
    end else if (take && wb_we_i) begin
      if (wb_adr_i == ASU_OFS_MODE) mode_reg <= asu_mode_t'(wb_dat_i[12:0]);
      if (wb_adr_i == ASU_OFS_CTRL) ctrl_reg <= asu_ctrl_t'(wb_dat_i[6:0]);
      if (wb_adr_i == ASU_OFS_TXB) loaded_reg <= 1'b1;
    end
  end

  // Marks a status read awaiting its answer
  always_ff @(posedge clk_i) begin
    rd_stat_reg <= !rst_i && take && !wb_we_i && (wb_adr_i == ASU_OFS_STAT);
  end

  property p_idle_high;
    !loaded_reg && !mode_reg.pol_rev && !mode_reg.open_drain
      |-> serial_out_pin_o && serial_out_pin_oe_o;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("line not idle high");
  property p_od_low;
    mode_reg.open_drain |-> !serial_out_pin_o;
  endproperty
  a_od_low: assert property (p_od_low) else $error("open drain drives high");
  property p_pp_oe;
    !mode_reg.open_drain |-> serial_out_pin_oe_o;
  endproperty
  a_pp_oe: assert property (p_pp_oe) else $error("push-pull output released");
  property p_hs_oe;
    $stable(ctrl_reg) |-> hs_pin_oe_o == (!ctrl_reg.hs_dis && ctrl_reg.hs_func_rts);
  endproperty
  a_hs_oe: assert property (p_hs_oe) else $error("handshake pin role wrong");
  property p_rts_off;
    hs_pin_oe_o && !ctrl_reg.rx_en && $stable(ctrl_reg) |-> hs_pin_o;
  endproperty
  a_rts_off: assert property (p_rts_off) else $error("request to send low while off");
  property p_txdone_line;
    tx_irq_req_o && ctrl_reg.tx_irq_done && !mode_reg.pol_rev && !mode_reg.open_drain
      |-> $past(serial_out_pin_o, 2);
  endproperty
  a_txdone_line: assert property (p_txdone_line) else $error("done request before stop");
  property p_txirq_pulse;
    tx_irq_req_o |=> !tx_irq_req_o;
  endproperty
  a_txirq_pulse: assert property (p_txirq_pulse) else $error("transmit request too long");
  property p_rxirq_gap;
    rx_irq_req_o |=> !rx_irq_req_o [*8];
  endproperty
  a_rxirq_gap: assert property (p_rxirq_gap) else $error("receive requests too close");
  property p_ack_one;
    take |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack not one cycle later");
  property p_sum;
    rd_stat_reg && wb_ack_o |-> wb_dat_o[ASU_ST_SUM] == |wb_dat_o[ASU_ST_PAR:ASU_ST_OVR];
  endproperty
  a_sum: assert property (p_sum) else $error("error sum mismatch");

  // Main scenarios reached
  c_done: cover property (tx_irq_req_o && ctrl_reg.tx_irq_done);
  c_rx: cover property (rx_irq_req_o);
  c_ovr: cover property (rd_stat_reg && wb_ack_o && wb_dat_o[ASU_ST_OVR]);
endmodule

bind asu_uart asu_chk asu_chk_i (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .serial_in_pin_i(serial_in_pin_i),
  .serial_out_pin_o(serial_out_pin_o), .serial_out_pin_oe_o(serial_out_pin_oe_o),
  .transfer_clock_pin_i(transfer_clock_pin_i), .hs_pin_i(hs_pin_i), .hs_pin_o(hs_pin_o),
  .hs_pin_oe_o(hs_pin_oe_o), .tx_irq_req_o(tx_irq_req_o), .rx_irq_req_o(rx_irq_req_o)
);

// ### asu_peer.sv
/*
  Remote serial device: sends and captures frames bit by bit.
  Assumes the bench hands it whole frames at line level, LSB first.
*/
`timescale 1ns/1ps
module asu_peer (
  // Clock and line
  input  wire logic clk_i,
  input  wire logic line_i,
  output logic      line_o
);
  // Mark level while idle
  initial line_o = 1'b1;

  // Start, character, parity, stops; last bit held past its centre only
  task automatic send(input logic [12:0] f, input int nb, input int per);
    for (int i = 0; i < nb; i++) begin
      @(posedge clk_i) line_o <= f[i];
      repeat ((i == nb - 1) ? per / 2 + 8 : per - 1) @(posedge clk_i);
    end
    @(posedge clk_i) line_o <= 1'b1;
    repeat (per) @(posedge clk_i);
  endtask

  // Waits for a start edge, then samples each bit at its centre
  task automatic grab(input int nb, input int per, input logic inv, output logic [12:0] f);
    f = '0;
    @(posedge clk_i);
    while (line_i !== inv) @(posedge clk_i);
    repeat (per / 2) @(posedge clk_i);
    for (int i = 0; i < nb; i++) begin
      f[i] = line_i ^ inv;
      repeat (per) @(posedge clk_i);
    end
  endtask
endmodule

// ### async_serial_uart_mode_tb.sv
/*
  Self-checking bench for asu_uart: register access, frames both ways.
  Assumes asu_peer as the remote device and a pull-up on the output line.
*/
`timescale 1ns/1ps
module async_serial_uart_mode_tb;
  import asu_pkg::*;
  localparam logic [12:0] TXM [9] = '{13'h0000, 13'h01c1, 13'h0042, 13'h0011, 13'h0021,
                                      13'h0009, 13'h0401, 13'h0801, 13'h1001};
  localparam logic [8:0]  TXD [9] = '{9'h055, 9'h0b3, 9'h1a6, 9'h03c, 9'h081, 9'h05a,
                                      9'h00f, 9'h096, 9'h069};
  localparam int          TXP [9] = '{32, 32, 32, 256, 1024, 262, 32, 32, 32};
  logic        clk_i, rst_i, cyc, we, ext_clk, cts_n, ack, sout, soe, hs_o, hs_oe;
  logic        tx_irq, rx_irq, line, peer_line;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat, r;
  logic [12:0] got, fr;
  int          fail_count, n_checks, tx_irqs, rx_irqs, cycles, nb, c0;

  asu_uart asu_uart_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .serial_in_pin_i(peer_line), .serial_out_pin_o(sout), .serial_out_pin_oe_o(soe),
    .transfer_clock_pin_i(ext_clk), .hs_pin_i(cts_n), .hs_pin_o(hs_o), .hs_pin_oe_o(hs_oe),
    .tx_irq_req_o(tx_irq), .rx_irq_req_o(rx_irq));
  asu_peer asu_peer_i (.clk_i(clk_i), .line_i(line), .line_o(peer_line));

  // Pull-up on the output wire
  assign line = soe ? sout : 1'b1;
  always #5 clk_i = ~clk_i;
  always #41 ext_clk = ~ext_clk;

  // Request counters and watchdog
  always @(posedge clk_i) begin
    cycles++;
    if (tx_irq === 1'b1) tx_irqs++;
    if (rx_irq === 1'b1) rx_irqs++;
    if (cycles == 80000) begin
      fail_count++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // One classic cycle, held until ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    we <= 1'b0;
  endtask

  // Line image of a frame; flaw[0] bad parity, flaw[1] bad last stop
  function automatic logic [12:0] mk(input asu_mode_t m, input logic [8:0] d,
                                     input logic [1:0] flaw, output int n);
    int   len;
    logic p;
    logic [12:0] f;
    len = (m.len == ASU_LEN7) ? 7 : (m.len == ASU_LEN8) ? 8 : 9;
    f = '0;
    p = 1'b0;
    n = 1;
    for (int i = 0; i < len; i++) begin
      f[n] = d[i];
      p ^= d[i];
      n++;
    end
    if (m.par_en) begin
      f[n] = (p ~^ m.par_even) ^ flaw[0];
      n++;
    end
    f[n] = 1'b1;
    n++;
    if (m.two_stop) begin
      f[n] = 1'b1;
      n++;
    end
    f[n - 1] = ~flaw[1];
    return f;
  endfunction

  task automatic tx_case(input int i);
    int cm;
    asu_mode_t m;
    logic [12:0] e;
    m = asu_mode_t'(TXM[i]);
    e = mk(m, m.data_inv ? ~TXD[i] : TXD[i], 2'h0, nb);
    wb(1'b1, ASU_OFS_MODE, {19'h0, TXM[i]});
    wb(1'b1, ASU_OFS_CTRL, (i == 1) ? 32'h31 : 32'h21);
    c0 = tx_irqs;
    fork
      begin
        wb(1'b1, ASU_OFS_TXB, {23'h0, TXD[i]});
        repeat (4) @(posedge clk_i);
        cm = tx_irqs;
      end
      asu_peer_i.grab(nb, TXP[i], m.pol_rev, got);
    join
    chk({19'h0, got}, {19'h0, e});
    chk(32'(cm - c0), (i == 1) ? 32'h0 : 32'h1);
    repeat (TXP[i]) @(posedge clk_i);
    chk(32'(tx_irqs - c0), 32'h1);
  endtask

  task automatic rx_case(input logic [12:0] mode, input logic [8:0] d, input logic [1:0] flaw,
                         input logic pre, input int irq, input logic [31:0] st,
                         input logic [31:0] rxb);
    wb(1'b1, ASU_OFS_MODE, {19'h0, mode});
    c0 = rx_irqs;
    chk({31'h0, hs_o}, 32'h0);
    fr = mk(asu_mode_t'(mode), d, flaw, nb);
    if (pre) asu_peer_i.send(mk(asu_mode_t'(mode), 9'h011, 2'h0, nb), nb, 32);
    asu_peer_i.send(fr, nb, 32);
    chk(32'(rx_irqs - c0), 32'(irq));
    chk({31'h0, hs_o}, {31'h0, st[0]});
    wb(1'b0, ASU_OFS_STAT, 32'h0);
    chk(r & 32'h79, st);
    wb(1'b0, ASU_OFS_RXB, 32'h0);
    if (st[0]) chk(r, rxb);
    wb(1'b1, ASU_OFS_STAT, 32'h38);
  endtask

  initial begin
    {clk_i, cyc, we, ext_clk, adr, wdat, fail_count, n_checks, tx_irqs, rx_irqs, cycles} = '0;
    {rst_i, cts_n} = 2'b11;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    // Reset values and an unmapped place
    wb(1'b1, 8'h20, 32'hffffffff);
    for (int i = 0; i < 4; i++) begin
      wb(1'b0, (i == 3) ? 8'h20 : 8'(4 * i), 32'h0);
      chk(r, (i == 0) ? 32'h1 : 32'h0);
    end
    wb(1'b0, ASU_OFS_STAT, 32'h0);
    chk(r & 32'h7b, 32'h2);
    wb(1'b1, ASU_OFS_BRG, 32'h1);
    for (int i = 0; i < 9; i++) tx_case(i);
    // Clear to send holds back a loaded character
    wb(1'b1, ASU_OFS_MODE, 32'h1);
    wb(1'b1, ASU_OFS_CTRL, 32'h1);
    wb(1'b1, ASU_OFS_TXB, 32'h33);
    repeat (100) @(posedge clk_i);
    chk({31'h0, line}, 32'h1);
    wb(1'b0, ASU_OFS_STAT, 32'h0);
    chk(r & 32'h2, 32'h0);
    fork
      cts_n <= 1'b0;
      asu_peer_i.grab(10, 32, 1'b0, got);
    join
    chk({19'h0, got}, {19'h0, mk(asu_mode_t'(13'h1), 9'h033, 2'h0, nb)});
    // Receiver off: nothing taken, request to send high
    wb(1'b1, ASU_OFS_CTRL, 32'h40);
    c0 = rx_irqs;
    asu_peer_i.send(mk(asu_mode_t'(13'h1), 9'h05a, 2'h0, nb), nb, 32);
    chk(32'(rx_irqs - c0), 32'h0);
    chk({30'h0, hs_oe, hs_o}, 32'h3);
    wb(1'b1, ASU_OFS_CTRL, 32'h44);
    rx_case(13'h00c1, 9'h0a5, 2'h0, 1'b0, 1, 32'h01, 32'h0a5);
    rx_case(13'h00c1, 9'h03c, 2'h1, 1'b0, 1, 32'h61, 32'h03c);
    rx_case(13'h0101, 9'h07e, 2'h2, 1'b0, 1, 32'h51, 32'h07e);
    rx_case(13'h0001, 9'h044, 2'h0, 1'b1, 1, 32'h49, 32'h044);
    rx_case(13'h0201, 9'h012, 2'h0, 1'b0, 0, 32'h00, 32'h000);
    rx_case(13'h0201, 9'h092, 2'h0, 1'b0, 1, 32'h01, 32'h092);
    rx_case(13'h0401, 9'h00f, 2'h0, 1'b0, 1, 32'h01, 32'h0f0);
    report_and_stop();
  end
endmodule
